// >>> lpms_sup.sv
// Low-power mode supervisor with AXI4-Lite register slave
//
// Overview of operation
// - Stop keeps regulator on and freezes watchdog, switches, buses, cyclic functions.
// - Bridge drivers and charge pump off in Stop, Sleep, Restart, Fail-Safe.
// - Low-side braking stays allowed in Stop.
// - Sleep turns regulator and watchdog off; wake detection and cyclic functions run.
// - Sleep keeps switches and cyclic functions as configured in Normal.
// - Sleep keeps each bus off if configured off, else makes it wake-capable.
// - Low-side braking stays allowed in Sleep.
// - Restart is transitional and drives the reset output asserted.
// - Restart disables watchdog, switches and cyclic functions.
// - Regulator stays on during Restart.
// - Restart bus state is woken, wake-capable or off.
// - Fail-Safe turns off regulator, watchdog, switches and cyclic functions.
// - Fail-Safe forces both buses wake-capable.
// - Fail-Safe entry enables default wake sources and clears wake events.
// - Fail-safe output pin activates in Fail-Safe when so configured.
// - Fail-Safe holds for the dwell time; stored wakes then trigger Restart.
// - After overtemperature clears, Restart follows the recovery time without wake.
// - Parking braking is disabled in Fail-Safe.
// - Stop ignores writes and flags failure, except mode, reset, refresh, clear.
`timescale 1ns/1ps
module lpms_sup
  import lpms_pkg::*;
#(
  parameter int unsigned FS_DWELL_CYCLES = FS_DWELL_CYC,
  parameter int unsigned OT_REC_CYCLES = OT_REC_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [LPMS_AW-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [LPMS_AW-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic overtemp_in,
  input wire logic ov_brake_in,
  input wire logic [1:0] bus_wake_in,
  input wire logic [WKP_N-1:0] wake_input_pins,
  input wire logic fail_event,
  input wire logic restart_event,
  output logic main_regulator,
  output logic watchdog_en,
  output logic wd_refresh,
  output logic soft_reset,
  output logic [HS_N-1:0] high_side_switches,
  output logic bridge_gate_drivers,
  output logic charge_pump,
  output logic low_side_brake_en,
  output logic [3:0] bus_state,
  output logic cyclic_sense_en,
  output logic cyclic_wake_en,
  output logic reset_output_n,
  output logic fail_safe_output_pin,
  output logic [EV_W-1:0] wake_src_en,
  output logic [4:0] mode_o
);

  typedef struct packed {
    lpms_mode_t mode;
    logic [CFG_W-1:0] cfg;
    logic spi_fail;
    logic [EV_W-1:0] wake_ev;
    logic tsd;
    logic [RST_CNT_W-1:0] rst_cnt;
    logic [WKP_N+3:0] sync1;
    logic [WKP_N+3:0] sync2;
    logic aw_v;
    logic [LPMS_AW-1:0] aw_addr;
    logic w_v;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic main_reg;
    logic wd_en;
    logic wd_ref;
    logic srst;
    logic [HS_N-1:0] hs;
    logic bd;
    logic cp;
    logic ls_brk;
    logic [3:0] bus;
    logic cs;
    logic cw;
    logic rst_n;
    logic fo;
    logic [EV_W-1:0] wsrc;
  } lpms_st_t;

  lpms_st_t s_q;
  lpms_st_t s_d;

  lpms_tmr_if dwell_if ();
  lpms_tmr_if ot_if ();

  lpms_timer #(.LEN(FS_DWELL_CYCLES), .W(TMR_W)) u_dwell (
    .aclk(aclk),
    .aresetn(aresetn),
    .t(dwell_if.tmr)
  );

  lpms_timer #(.LEN(OT_REC_CYCLES), .W(TMR_W)) u_ot (
    .aclk(aclk),
    .aresetn(aresetn),
    .t(ot_if.tmr)
  );

  function automatic logic [31:0] wmerge(logic [31:0] o, logic [31:0] d, logic [3:0] st);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [1:0] bus_map(lpms_mode_t m, logic [1:0] c, logic woken);
    logic [1:0] r;
    r = c;
    if (m == LPMS_FAILSAFE) begin
      r = BUS_WAKE;
    end else if (m == LPMS_SLEEP) begin
      r = (c == BUS_OFF) ? BUS_OFF : BUS_WAKE;
    end else if (m == LPMS_RESTART) begin
      r = woken ? BUS_WOKEN : ((c == BUS_OFF) ? BUS_OFF : BUS_WAKE);
    end
    return r;
  endfunction

  logic ot;
  logic ovb;
  logic [1:0] bus_w;
  logic [WKP_N-1:0] pin_w;
  logic [EV_W-1:0] ev_in;
  logic [EV_W-1:0] clr_ev;
  logic do_wr;
  logic sw_req;
  logic [2:0] req;
  logic srst;
  logic fail_set;
  logic clr_fail;
  logic locked;
  logic fs_entry;
  logic [31:0] merged;

  always_comb begin
    s_d = s_q;
    s_d.wd_ref = 1'b0;
    s_d.srst = 1'b0;
    // Pins pass two flops before anything looks at them
    s_d.sync1 = {ov_brake_in, overtemp_in, wake_input_pins, bus_wake_in};
    s_d.sync2 = s_q.sync1;
    bus_w = s_q.sync2[1:0];
    pin_w = s_q.sync2[WKP_N+1:2];
    ot = s_q.sync2[WKP_N+2];
    ovb = s_q.sync2[WKP_N+3];
    ev_in[0] = bus_w[0] && (s_q.cfg[CFG_BUS0_LSB +: 2] != BUS_OFF || s_q.mode == LPMS_FAILSAFE);
    ev_in[1] = bus_w[1] && (s_q.cfg[CFG_BUS1_LSB +: 2] != BUS_OFF || s_q.mode == LPMS_FAILSAFE);
    ev_in[EV_W-1:2] = pin_w & s_q.cfg[CFG_WKP_LSB +: WKP_N];
    clr_ev = '0;
    sw_req = 1'b0;
    req = REQ_NORMAL;
    srst = 1'b0;
    fail_set = 1'b0;
    clr_fail = 1'b0;
    merged = '0;
    locked = (s_q.mode == LPMS_STOP) || (s_q.mode == LPMS_SLEEP);

    if (awvalid && s_q.awready) begin
      s_d.aw_v = 1'b1;
      s_d.aw_addr = awaddr;
    end
    if (wvalid && s_q.wready) begin
      s_d.w_v = 1'b1;
      s_d.w_data = wdata;
      s_d.w_strb = wstrb;
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    do_wr = s_q.aw_v && s_q.w_v && !s_q.bvalid;
    if (do_wr) begin
      s_d.aw_v = 1'b0;
      s_d.w_v = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      unique case (s_q.aw_addr)
        CTRL_OFS: begin
          if (s_q.w_strb[0]) begin
            sw_req = 1'b1;
            req = s_q.w_data[CTRL_MODE_LSB +: 3];
            srst = s_q.w_data[CTRL_SRST];
            s_d.wd_ref = s_q.w_data[CTRL_WDREF];
          end
        end
        CFG_OFS: begin
          // Configuration is frozen in Stop and Sleep so those low-power modes see Normal settings
          merged = wmerge(32'(s_q.cfg), s_q.w_data, s_q.w_strb);
          if (locked) begin
            fail_set = 1'b1;
          end else begin
            s_d.cfg = merged[CFG_W-1:0];
          end
        end
        STAT_OFS: begin
          clr_fail = s_q.w_strb[0] && s_q.w_data[STAT_FAIL];
          clr_ev = s_q.w_strb[1] ? s_q.w_data[STAT_EV_LSB +: EV_W] : '0;
        end
        default: begin
          s_d.bresp = RESP_SLVERR;
        end
      endcase
    end

    if (arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      unique case (araddr)
        CTRL_OFS: s_d.rdata = 32'(s_q.mode);
        CFG_OFS: s_d.rdata = 32'(s_q.cfg);
        STAT_OFS: begin
          s_d.rdata = '0;
          s_d.rdata[STAT_FAIL] = s_q.spi_fail;
          s_d.rdata[STAT_TSD] = s_q.tsd;
          s_d.rdata[STAT_DWELL] = dwell_if.expired;
          s_d.rdata[STAT_EV_LSB +: EV_W] = s_q.wake_ev;
        end
        default: begin
          s_d.rdata = '0;
          s_d.rresp = RESP_SLVERR;
        end
      endcase
    end else if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end

    unique case (s_q.mode)
      LPMS_NORMAL: begin
        if (sw_req && !srst) begin
          if (req == REQ_STOP) begin
            s_d.mode = LPMS_STOP;
          end else if (req == REQ_SLEEP) begin
            s_d.mode = LPMS_SLEEP;
          end else if (req != REQ_NORMAL) begin
            fail_set = 1'b1;
          end
        end
      end
      LPMS_STOP: begin
        // Wake events only raise flags here; the host or a restart, fail or overtemperature event decides when to leave Stop
        if (sw_req && !srst) begin
          if (req == REQ_NORMAL) begin
            s_d.mode = LPMS_NORMAL;
          end else if (req == REQ_SLEEP) begin
            fail_set = 1'b1;
            s_d.mode = LPMS_RESTART;
          end else if (req != REQ_STOP) begin
            // Staying in Stop is how a watchdog refresh gets through without a failure flag
            fail_set = 1'b1;
          end
        end
      end
      LPMS_SLEEP: begin
        if (sw_req) begin
          fail_set = 1'b1;
        end
        if (|s_q.wake_ev) begin
          s_d.mode = LPMS_RESTART;
        end
      end
      LPMS_RESTART: begin
        // Fixed short Restart stands in for the reset delay
        if (s_q.rst_cnt == RST_CNT_W'(RESTART_CYC - 1)) begin
          s_d.mode = LPMS_NORMAL;
        end
      end
      LPMS_FAILSAFE: begin
        if (dwell_if.expired && (|s_q.wake_ev)) begin
          s_d.mode = LPMS_RESTART;
        end else if (ot_if.expired) begin
          s_d.mode = LPMS_RESTART;
        end
      end
    endcase

    if (srst && (s_q.mode == LPMS_NORMAL || s_q.mode == LPMS_STOP)) begin
      s_d.mode = LPMS_NORMAL;
      s_d.cfg = CFG_RST;
      s_d.srst = 1'b1;
    end
    if (restart_event && s_q.mode != LPMS_FAILSAFE) begin
      s_d.mode = LPMS_RESTART;
    end
    if ((ot || fail_event) && s_q.mode != LPMS_FAILSAFE) begin
      s_d.mode = LPMS_FAILSAFE;
    end

    fs_entry = (s_d.mode == LPMS_FAILSAFE) && (s_q.mode != LPMS_FAILSAFE);
    s_d.rst_cnt = (s_q.mode == LPMS_RESTART) ? s_q.rst_cnt + RST_CNT_W'(1) : '0;
    s_d.tsd = (s_q.tsd || ot) && (s_d.mode == LPMS_FAILSAFE);
    // A new event wins over a clear in the same cycle
    s_d.spi_fail = (s_q.spi_fail && !clr_fail) || fail_set;
    s_d.wake_ev = (s_q.wake_ev & ~clr_ev & ~{EV_W{fs_entry}}) | ev_in;
    s_d.awready = !s_d.aw_v;
    s_d.wready = !s_d.w_v;
    s_d.arready = !s_d.rvalid;

    dwell_if.clear = fs_entry || (s_q.mode != LPMS_FAILSAFE);
    dwell_if.run = (s_q.mode == LPMS_FAILSAFE);
    ot_if.clear = ot || (s_q.mode != LPMS_FAILSAFE);
    ot_if.run = s_q.tsd;

    // Enables follow the next mode so they switch on the same edge as the mode
    s_d.main_reg = !(s_d.mode == LPMS_SLEEP || s_d.mode == LPMS_FAILSAFE);
    s_d.wd_en = (s_d.mode == LPMS_NORMAL || s_d.mode == LPMS_STOP) && s_d.cfg[CFG_WD];
    s_d.hs = '0;
    s_d.cs = 1'b0;
    s_d.cw = 1'b0;
    s_d.ls_brk = 1'b0;
    if (s_d.mode == LPMS_NORMAL || s_d.mode == LPMS_STOP || s_d.mode == LPMS_SLEEP) begin
      s_d.hs = s_d.cfg[CFG_HS_LSB +: HS_N];
      s_d.cs = s_d.cfg[CFG_CS];
      s_d.cw = s_d.cfg[CFG_CW];
      s_d.ls_brk = s_d.cfg[CFG_PARK] || ovb;
    end
    s_d.bd = (s_d.mode == LPMS_NORMAL) && s_d.cfg[CFG_BD];
    s_d.cp = (s_d.mode == LPMS_NORMAL) && s_d.cfg[CFG_CP];
    s_d.bus[1:0] = bus_map(s_d.mode, s_d.cfg[CFG_BUS0_LSB +: 2], s_d.wake_ev[0]);
    s_d.bus[3:2] = bus_map(s_d.mode, s_d.cfg[CFG_BUS1_LSB +: 2], s_d.wake_ev[1]);
    // Reset stays asserted whenever the host is unpowered or restarting
    s_d.rst_n = (s_d.mode == LPMS_NORMAL || s_d.mode == LPMS_STOP);
    s_d.fo = (s_d.mode == LPMS_FAILSAFE) && s_d.cfg[CFG_FO];
    s_d.wsrc[EV_W-1:2] = s_d.cfg[CFG_WKP_LSB +: WKP_N];
    s_d.wsrc[0] = (s_d.mode == LPMS_FAILSAFE) || (s_d.cfg[CFG_BUS0_LSB +: 2] != BUS_OFF);
    s_d.wsrc[1] = (s_d.mode == LPMS_FAILSAFE) || (s_d.cfg[CFG_BUS1_LSB +: 2] != BUS_OFF);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.mode <= LPMS_NORMAL;
      s_q.cfg <= CFG_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign awready = s_q.awready;
  assign wready = s_q.wready;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign arready = s_q.arready;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign main_regulator = s_q.main_reg;
  assign watchdog_en = s_q.wd_en;
  assign wd_refresh = s_q.wd_ref;
  assign soft_reset = s_q.srst;
  assign high_side_switches = s_q.hs;
  assign bridge_gate_drivers = s_q.bd;
  assign charge_pump = s_q.cp;
  assign low_side_brake_en = s_q.ls_brk;
  assign bus_state = s_q.bus;
  assign cyclic_sense_en = s_q.cs;
  assign cyclic_wake_en = s_q.cw;
  assign reset_output_n = s_q.rst_n;
  assign fail_safe_output_pin = s_q.fo;
  assign wake_src_en = s_q.wsrc;
  assign mode_o = s_q.mode;

  AST_BD_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.mode != LPMS_NORMAL) |-> (!bridge_gate_drivers && !charge_pump))
    else $error("bridge drivers or charge pump on outside Normal");

  AST_STOP_FROZEN: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.mode == LPMS_STOP) && $past(s_q.mode) == LPMS_STOP |-> $stable(high_side_switches) && $stable(bus_state)
      && $stable(watchdog_en) && main_regulator)
    else $error("Stop outputs changed or regulator off");

  AST_SLEEP_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(s_q.mode == LPMS_SLEEP) |-> !main_regulator && !watchdog_en && !reset_output_n)
    else $error("regulator or watchdog not off on Sleep entry");

  AST_SLEEP_BUS: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.mode == LPMS_SLEEP) |-> bus_state[1:0] != BUS_ACT && bus_state[3:2] != BUS_ACT)
    else $error("bus active in Sleep");

  AST_RESTART: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.mode == LPMS_RESTART) |-> !reset_output_n && main_regulator && high_side_switches == '0
      && !cyclic_sense_en && !cyclic_wake_en && !watchdog_en)
    else $error("Restart outputs wrong");

  AST_FS_OUT: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.mode == LPMS_FAILSAFE) |-> !main_regulator && bus_state == {BUS_WAKE, BUS_WAKE}
      && !low_side_brake_en && fail_safe_output_pin == s_q.cfg[CFG_FO])
    else $error("Fail-Safe outputs wrong");

  AST_FS_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.mode == LPMS_FAILSAFE) && !dwell_if.expired && !ot_if.expired |=> s_q.mode != LPMS_RESTART)
    else $error("Fail-Safe left before dwell or recovery");

  AST_FS_CLR: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(s_q.mode == LPMS_FAILSAFE) |-> (s_q.wake_ev & ~$past(ev_in)) == '0 && wake_src_en[1:0] == 2'h3)
    else $error("wake events not cleared on Fail-Safe entry");

  AST_STOP_WR: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.mode == LPMS_STOP) && do_wr && s_q.aw_addr == CFG_OFS |=> s_q.spi_fail && $stable(s_q.cfg))
    else $error("write in Stop not refused");

  AST_OT_REC: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.mode == LPMS_FAILSAFE) && ot_if.expired && !ot && !fail_event |=> s_q.mode == LPMS_RESTART)
    else $error("no Restart after overtemperature recovery");

endmodule

// >>> lpms_pkg.sv
// Constants, register map and types for the low-power mode supervisor
package lpms_pkg;

  // Register byte offsets
  localparam int LPMS_AW = 4;
  localparam logic [LPMS_AW-1:0] CTRL_OFS = 4'h0;
  localparam logic [LPMS_AW-1:0] CFG_OFS = 4'h4;
  localparam logic [LPMS_AW-1:0] STAT_OFS = 4'h8;

  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SRST = 4;
  localparam int CTRL_WDREF = 5;
  localparam logic [2:0] REQ_NORMAL = 3'h0;
  localparam logic [2:0] REQ_STOP = 3'h1;
  localparam logic [2:0] REQ_SLEEP = 3'h2;

  // Configuration register fields
  localparam int CFG_W = 19;
  localparam int CFG_HS_LSB = 0;
  localparam int HS_N = 4;
  localparam int CFG_WD = 4;
  localparam int CFG_BD = 5;
  localparam int CFG_CP = 6;
  localparam int CFG_CS = 7;
  localparam int CFG_CW = 8;
  localparam int CFG_BUS0_LSB = 9;
  localparam int CFG_BUS1_LSB = 11;
  localparam int CFG_PARK = 13;
  localparam int CFG_FO = 14;
  localparam int CFG_WKP_LSB = 15;
  localparam int WKP_N = 4;
  localparam logic [CFG_W-1:0] CFG_RST = 19'h00000;

  // Status register fields
  localparam int STAT_FAIL = 0;
  localparam int STAT_TSD = 1;
  localparam int STAT_DWELL = 2;
  localparam int STAT_EV_LSB = 8;
  localparam int EV_W = 6;

  // Bus transceiver states
  localparam logic [1:0] BUS_OFF = 2'h0;
  localparam logic [1:0] BUS_WAKE = 2'h1;
  localparam logic [1:0] BUS_ACT = 2'h2;
  localparam logic [1:0] BUS_WOKEN = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing
  localparam int CLK_HZ = 20000000;
  localparam int FS_DWELL_MS = 100;
  localparam int OT_REC_MS = 1000;
  localparam int FS_DWELL_CYC = FS_DWELL_MS * (CLK_HZ / 1000);
  localparam int OT_REC_CYC = OT_REC_MS * (CLK_HZ / 1000);
  localparam int TMR_W = 25;
  localparam int RESTART_CYC = 16;
  localparam int RST_CNT_W = 5;

  typedef enum logic [4:0] {
    LPMS_NORMAL = 5'h01,
    LPMS_STOP = 5'h02,
    LPMS_SLEEP = 5'h04,
    LPMS_RESTART = 5'h08,
    LPMS_FAILSAFE = 5'h10
  } lpms_mode_t;

endpackage

// >>> lpms_tmr_if.sv
// Control and status lines between the supervisor and one of its timers
`timescale 1ns/1ps
interface lpms_tmr_if;
  logic clear;
  logic run;
  logic expired;
  modport ctl (output clear, output run, input expired);
  modport tmr (input clear, input run, output expired);
endinterface

// >>> lpms_timer.sv
// Sticky expiry timer used for the fail-safe dwell and overtemperature recovery time
`timescale 1ns/1ps
module lpms_timer
  import lpms_pkg::*;
#(
  parameter int unsigned LEN = 16,
  parameter int W = TMR_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  lpms_tmr_if.tmr t
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic done;
  } lpms_tmr_st_t;

  lpms_tmr_st_t s_q;
  lpms_tmr_st_t s_d;

  always_comb begin
    s_d = s_q;
    if (t.clear) begin
      s_d.cnt = '0;
      s_d.done = 1'b0;
    end else if (t.run && !s_q.done) begin
      if (s_q.cnt == W'(LEN - 1)) begin
        s_d.done = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign t.expired = s_q.done;

endmodule

// >>> lpms_host.sv
// Host-side AXI4-Lite master model for the supervisor register port
`timescale 1ns/1ps
module lpms_host
  import lpms_pkg::*;
(
  input wire logic aclk,
  output logic awvalid,
  input wire logic awready,
  output logic [LPMS_AW-1:0] awaddr,
  output logic wvalid,
  input wire logic wready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  input wire logic bvalid,
  output logic bready,
  output logic arvalid,
  input wire logic arready,
  output logic [LPMS_AW-1:0] araddr,
  input wire logic rvalid,
  output logic rready
);
  // Bounded waits: a stuck slave is reported through ok rather than hanging the run
  localparam int WAIT_MAX = 64;
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
  end
  task automatic wr(input logic [LPMS_AW-1:0] a, input logic [31:0] d, output bit ok);
    int n;
    ok = 1'b0;
    // Start one edge on so a back-to-back call never reassigns bready in the step that released it
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < WAIT_MAX && !ok; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        bready <= 1'b0;
        ok = 1'b1;
      end
    end
  endtask
  task automatic rd(input logic [LPMS_AW-1:0] a, output bit ok);
    int n;
    ok = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < WAIT_MAX && !ok; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        rready <= 1'b0;
        ok = 1'b1;
      end
    end
  endtask
endmodule

// >>> low_power_mode_supervisor_bench.sv
// Self-checking bench for the low-power mode supervisor
`timescale 1ns/1ps
`define CHK(act, exp, msk) begin tests_run++; if (((act) & (msk)) !== ((exp) & (msk))) begin err_total++; \
  $display("wrong value at %0t: got %h expected %h", $time, act, exp); end end
module low_power_mode_supervisor_bench;
  import lpms_pkg::*;
  typedef struct {logic [31:0] e; logic [31:0] m;} lpms_note_t;
  localparam logic [31:0] CFGV = 32'h0000edff;
  localparam logic [31:0] MNF = 32'h0fffff80;
  localparam logic [31:0] MMODE = 32'h0f800000;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [LPMS_AW-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, snap, s;
  logic [3:0] wstrb, bus_state;
  logic [1:0] bresp, rresp, bus_wake_in;
  logic overtemp_in, ov_brake_in, fail_event, restart_event, main_regulator, watchdog_en, wd_refresh, soft_reset;
  logic bridge_gate_drivers, charge_pump, low_side_brake_en, cyclic_sense_en, cyclic_wake_en;
  logic reset_output_n, fail_safe_output_pin;
  logic [HS_N-1:0] high_side_switches;
  logic [WKP_N-1:0] wake_input_pins;
  logic [EV_W-1:0] wake_src_en;
  logic [4:0] mode_o;
  int err_total = 0;
  int tests_run = 0;
  lpms_note_t notes[$];
  event look;
  lpms_sup #(.FS_DWELL_CYCLES(20), .OT_REC_CYCLES(50)) dut (.aclk, .aresetn, .awvalid, .awready, .awaddr,
    .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
    .rdata, .rresp, .overtemp_in, .ov_brake_in, .bus_wake_in, .wake_input_pins, .fail_event, .restart_event,
    .main_regulator, .watchdog_en, .wd_refresh, .soft_reset, .high_side_switches, .bridge_gate_drivers,
    .charge_pump, .low_side_brake_en, .bus_state, .cyclic_sense_en, .cyclic_wake_en, .reset_output_n,
    .fail_safe_output_pin, .wake_src_en, .mode_o);
  lpms_host host (.aclk, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready,
    .arvalid, .arready, .araddr, .rvalid, .rready);
  assign snap = {4'h0, mode_o, main_regulator, watchdog_en, high_side_switches, bridge_gate_drivers, charge_pump,
    low_side_brake_en, bus_state, cyclic_sense_en, cyclic_wake_en, reset_output_n, fail_safe_output_pin, wake_src_en};
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic tally_and_finish();
    $display("counts: %0d checks, %0d wrong", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic fail(input string msg);
    err_total++;
    $display("wrong value at %0t: %s", $time, msg);
    tally_and_finish();
  endtask
  task automatic note(input logic [31:0] e, input logic [31:0] m);
    lpms_note_t n;
    n.e = e;
    n.m = m;
    notes.push_back(n);
  endtask
  task automatic pop_chk(input logic [31:0] a);
    lpms_note_t n;
    if (notes.size() == 0) begin
      fail("result with no note");
    end else begin
      n = notes.pop_front();
      `CHK(a, n.e, n.m)
    end
  endtask
  // The watchers on look, read data, strobes and responses compare; drivers leave notes, and wait_mode checks mode_o itself
  always @(look) pop_chk(snap);
  always @(posedge aclk) if (rvalid === 1'b1 && rready === 1'b1) begin
    pop_chk(rdata);
    `CHK(rresp, RESP_OKAY, 2'h3)
  end
  // Strobes stand one cycle; the negedge sees each exactly once, before the write response is taken
  always @(negedge aclk) if (wd_refresh === 1'b1 || soft_reset === 1'b1) pop_chk({30'h0, soft_reset, wd_refresh});
  always @(posedge aclk) if (bvalid === 1'b1 && bready === 1'b1) pop_chk({30'h0, bresp});
  task automatic ex(input logic [31:0] e, input logic [31:0] m);
    note(e, m);
    @(negedge aclk);
    -> look;
    @(posedge aclk);
  endtask
  task automatic w(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ok;
    note({30'h0, er}, 32'h3);
    host.wr(a, d, ok);
    if (!ok) fail("write hung");
  endtask
  task automatic r(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    bit ok;
    note(e, m);
    host.rd(a, ok);
    if (!ok) fail("read hung");
  endtask
  task automatic wait_mode(input logic [4:0] m, input int lim);
    int n;
    for (n = 0; n < lim && mode_o !== m; n++) @(posedge aclk);
    tests_run++;
    if (mode_o !== m) fail("mode change missing");
  endtask
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  initial begin
    aresetn = 1'b0;
    {overtemp_in, ov_brake_in, fail_event, restart_event, bus_wake_in, wake_input_pins} = 10'h000;
    s = 32'd84;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    ex({4'h0, LPMS_NORMAL, 2'b10, 4'h0, 3'b000, 4'h0, 2'b00, 1'b1, 1'b0, 6'h00}, MNF);
    for (int i = 0; i < 3; i++) begin
      s = xs(s);
      w(CFG_OFS, s & 32'h7ffff, RESP_OKAY);
      r(CFG_OFS, s & 32'h7ffff, 32'h7ffff);
    end
    w(4'hc, 32'h0, RESP_SLVERR);
    w(CFG_OFS, CFGV, RESP_OKAY);
    ex({4'h0, LPMS_NORMAL, 2'b11, 4'hf, 3'b111, 4'h6, 2'b11, 1'b1, 1'b0, 6'h00}, MNF);
    $display("test registers done");
    w(CTRL_OFS, {29'h0, REQ_STOP}, RESP_OKAY);
    note(32'h1, 32'h3);
    w(CTRL_OFS, 32'h21, RESP_OKAY);
    ex({4'h0, LPMS_STOP, 2'b11, 4'hf, 3'b001, 4'h6, 2'b11, 1'b1, 1'b0, 6'h00}, MNF);
    r(STAT_OFS, 32'h0, 32'h1);
    w(CFG_OFS, 32'h0, RESP_OKAY);
    r(CFG_OFS, CFGV, 32'h7ffff);
    r(STAT_OFS, 32'h1, 32'h1);
    w(CTRL_OFS, {29'h0, REQ_NORMAL}, RESP_OKAY);
    r(CTRL_OFS, {27'h0, LPMS_NORMAL}, 32'h1f);
    w(STAT_OFS, 32'h1, RESP_OKAY);
    r(STAT_OFS, 32'h0, 32'h1);
    $display("test stop done");
    w(CTRL_OFS, {29'h0, REQ_SLEEP}, RESP_OKAY);
    ex({4'h0, LPMS_SLEEP, 2'b00, 4'hf, 3'b001, 4'h5, 2'b11, 1'b0, 1'b0, 6'h00}, MNF);
    wake_input_pins <= 4'h1;
    wait_mode(LPMS_RESTART, 20);
    ex({4'h0, LPMS_RESTART, 2'b10, 4'h0, 3'b000, 4'h0, 2'b00, 1'b0, 1'b0, 6'h00}, 32'h0fff8380);
    wake_input_pins <= 4'h0;
    wait_mode(LPMS_NORMAL, 40);
    $display("test sleep done");
    fail_event <= 1'b1;
    @(posedge aclk);
    fail_event <= 1'b0;
    wait_mode(LPMS_FAILSAFE, 8);
    ex({4'h0, LPMS_FAILSAFE, 2'b00, 4'h0, 3'b000, 4'h5, 2'b00, 1'b0, 1'b1, 6'h07}, 32'h0fffffff);
    r(STAT_OFS, 32'h0, 32'h3f00);
    bus_wake_in <= 2'b01;
    repeat (8) @(posedge aclk);
    ex({4'h0, LPMS_FAILSAFE, 23'h0}, MMODE);
    wait_mode(LPMS_RESTART, 40);
    bus_wake_in <= 2'b00;
    wait_mode(LPMS_NORMAL, 40);
    $display("test fail-safe done");
    overtemp_in <= 1'b1;
    wait_mode(LPMS_FAILSAFE, 8);
    repeat (4) @(posedge aclk);
    overtemp_in <= 1'b0;
    repeat (30) @(posedge aclk);
    ex({4'h0, LPMS_FAILSAFE, 23'h0}, MMODE);
    wait_mode(LPMS_RESTART, 60);
    wait_mode(LPMS_NORMAL, 40);
    $display("test overtemp done");
    w(CTRL_OFS, {29'h0, REQ_STOP}, RESP_OKAY);
    note(32'h2, 32'h3);
    w(CTRL_OFS, 32'h11, RESP_OKAY);
    r(CFG_OFS, 32'h0, 32'h7ffff);
    r(STAT_OFS, 32'h0, 32'h1);
    w(CTRL_OFS, {29'h0, REQ_STOP}, RESP_OKAY);
    ov_brake_in <= 1'b1;
    repeat (3) @(posedge aclk);
    ex({4'h0, LPMS_STOP, 2'b10, 4'h0, 3'b001, 4'h0, 2'b00, 1'b1, 1'b0, 6'h00}, MNF);
    restart_event <= 1'b1;
    @(posedge aclk);
    restart_event <= 1'b0;
    ov_brake_in <= 1'b0;
    wait_mode(LPMS_RESTART, 8);
    $display("test reset and brake done");
    tally_and_finish();
  end
endmodule
